// ==== design/pos_seq_map.svh ====
`ifndef POS_SEQ_MAP_SVH
`define POS_SEQ_MAP_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_PS 5000
`define STEP_TIME_US 1000
`define WAIT_EXTRA_US 1000
`define LOOP_TIME_NS 250000
`define STEP_CYCLES ((`STEP_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define WAIT_EXTRA_CYCLES ((`WAIT_EXTRA_US * 1000000) / `CLK_PERIOD_PS)
`define LOOP_CYCLES ((`LOOP_TIME_NS * 1000) / `CLK_PERIOD_PS)

// ---------------------------------------------------------------
// widths and command field layout
// ---------------------------------------------------------------
`define POS_BITS 16
`define CMD_OP_BITS 3
`define OP_NOP 3'h0
`define OP_READ_IN 3'h1
`define OP_SET_OUT 3'h2
`define OP_MOVE 3'h3
`define OP_MOVE_WAIT 3'h4
`define OP_SET_ACCEL 3'h5
`define OP_HOME 3'h6
`define OP_END 3'h7

`endif

// ==== design/pos_seq_pkg.sv ====
package pos_seq_pkg;

   typedef enum logic [1:0] {
      MODE_MANUAL,
      MODE_AUTO,
      MODE_HOMING
   } op_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_STEP,
      ST_WAIT_POS,
      ST_WAIT_EXTRA,
      ST_HOME_CAM,
      ST_HOME_ZERO
   } seq_state_t;

   // one stored or host command
   typedef struct packed {
      logic [2:0] op;
      logic [15:0] arg;
   } cmd_t;

   // motion request to the profile generator
   typedef struct packed {
      logic start;
      logic [15:0] target;
      logic jog_fast;
      logic jog_dir_neg;
      logic jog_run;
   } motion_t;

endpackage

// ==== design/positioning_mode_sequencer.sv ====
`timescale 1ns/1ps
`include "pos_seq_map.svh"

module positioning_mode_sequencer #(
   parameter int STEP_CYC = `STEP_CYCLES,
   parameter int EXTRA_CYC = `WAIT_EXTRA_CYCLES,
   parameter int LOOP_CYC = `LOOP_CYCLES,
   parameter int PROG_DEPTH = 256,
   parameter int PROG_SEL_BITS = 4,
   parameter int IO_BITS = 8
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic PROGRAM_RUN_SELECT_INPUT,
   input wire logic START,
   input wire logic [PROG_SEL_BITS-1:0] PROG_SEL,
   input wire logic PROG_WR,
   input wire logic [$clog2(PROG_DEPTH)-1:0] PROG_WR_ADDR,
   input wire pos_seq_pkg::cmd_t PROG_WR_DATA,
   input wire logic HOST_CMD_VALID,
   input wire pos_seq_pkg::cmd_t HOST_CMD,
   input wire logic HOST_JOG_FWD,
   input wire logic HOST_JOG_REV,
   input wire logic JOG_FWD_INPUT,
   input wire logic JOG_REV_INPUT,
   input wire logic JOG_FAST,
   input wire logic HOME_REQ,
   input wire logic REFERENCE_CAM_INPUT,
   input wire logic ENDLESS_AXIS,
   input wire logic [`POS_BITS-1:0] ENC_POS,
   input wire logic TARGET_REACHED,
   input wire logic [IO_BITS-1:0] DIG_IN,
   output logic [IO_BITS-1:0] DIG_OUT,
   output logic [`POS_BITS-1:0] ACCEL,
   output logic [IO_BITS-1:0] IN_SNAP,
   output pos_seq_pkg::motion_t MOTION,
   output pos_seq_pkg::op_mode_t MODE,
   output logic HOST_CMD_BUSY,
   output logic REF_VALID,
   output logic LOOP_TICK,
   output logic PROG_DONE
);

   localparam int AW = $clog2(PROG_DEPTH);
   localparam int PW = AW - PROG_SEL_BITS;

   pos_seq_pkg::cmd_t prog_mem [PROG_DEPTH];
   pos_seq_pkg::seq_state_t state_reg;
   pos_seq_pkg::cmd_t cmd_reg;
   logic [AW-1:0] pc_reg;
   logic [31:0] step_cnt_reg;
   logic [31:0] loop_cnt_reg;
   logic auto_run_reg;
   logic home_from_auto_reg;
   logic cam_seen_reg;
   logic manual;
   logic jog_fwd;
   logic jog_rev;

   assign manual = !PROGRAM_RUN_SELECT_INPUT;
   assign jog_fwd = HOST_JOG_FWD | JOG_FWD_INPUT;
   assign jog_rev = HOST_JOG_REV | JOG_REV_INPUT;

   // ---------------------------------------------------------------
   // program store
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (PROG_WR) begin
         prog_mem[PROG_WR_ADDR] <= PROG_WR_DATA;
      end
   end

   // ---------------------------------------------------------------
   // position loop tick
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         loop_cnt_reg <= '0;
         LOOP_TICK <= 1'b0;
      end else if (loop_cnt_reg == 32'(LOOP_CYC - 1)) begin
         loop_cnt_reg <= '0;
         LOOP_TICK <= 1'b1;
      end else begin
         loop_cnt_reg <= loop_cnt_reg + 32'h1;
         LOOP_TICK <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // mode output
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         MODE <= pos_seq_pkg::MODE_MANUAL;
      end else if (state_reg == pos_seq_pkg::ST_HOME_CAM ||
                   state_reg == pos_seq_pkg::ST_HOME_ZERO) begin
         MODE <= pos_seq_pkg::MODE_HOMING;
      end else if (manual) begin
         MODE <= pos_seq_pkg::MODE_MANUAL;
      end else begin
         MODE <= pos_seq_pkg::MODE_AUTO;
      end
   end

   // ---------------------------------------------------------------
   // reference valid
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         REF_VALID <= 1'b0;
      end else if (ENDLESS_AXIS) begin
         REF_VALID <= 1'b1;
      end else if (state_reg == pos_seq_pkg::ST_HOME_ZERO &&
                   ENC_POS == '0) begin
         REF_VALID <= 1'b1;
      end else if (state_reg == pos_seq_pkg::ST_HOME_CAM) begin
         REF_VALID <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         state_reg <= pos_seq_pkg::ST_IDLE;
         cmd_reg <= '0;
         pc_reg <= '0;
         step_cnt_reg <= '0;
         auto_run_reg <= 1'b0;
         home_from_auto_reg <= 1'b0;
         cam_seen_reg <= 1'b0;
         DIG_OUT <= '0;
         ACCEL <= '0;
         IN_SNAP <= '0;
         MOTION <= '0;
         HOST_CMD_BUSY <= 1'b0;
         PROG_DONE <= 1'b0;
      end else begin
         MOTION.start <= 1'b0;
         PROG_DONE <= 1'b0;
         MOTION.jog_run <= manual && state_reg == pos_seq_pkg::ST_IDLE &&
                           (jog_fwd ^ jog_rev);
         MOTION.jog_dir_neg <= jog_rev;
         MOTION.jog_fast <= JOG_FAST;
         case (state_reg)
            pos_seq_pkg::ST_IDLE: begin
               HOST_CMD_BUSY <= 1'b0;
               auto_run_reg <= 1'b0;
               if (HOME_REQ) begin
                  home_from_auto_reg <= 1'b0;
                  cam_seen_reg <= 1'b0;
                  state_reg <= pos_seq_pkg::ST_HOME_CAM;
               end else if (!manual && START) begin
                  auto_run_reg <= 1'b1;
                  pc_reg <= {PROG_SEL, PW'(0)};
                  state_reg <= pos_seq_pkg::ST_FETCH;
               end else if (manual && HOST_CMD_VALID) begin
                  cmd_reg <= HOST_CMD;
                  HOST_CMD_BUSY <= 1'b1;
                  step_cnt_reg <= '0;
                  state_reg <= pos_seq_pkg::ST_STEP;
               end
            end
            pos_seq_pkg::ST_FETCH: begin
               if (manual) begin
                  state_reg <= pos_seq_pkg::ST_IDLE;
               end else begin
                  cmd_reg <= prog_mem[pc_reg];
                  pc_reg <= pc_reg + AW'(1);
                  step_cnt_reg <= '0;
                  state_reg <= pos_seq_pkg::ST_STEP;
               end
            end
            pos_seq_pkg::ST_STEP: begin
               step_cnt_reg <= step_cnt_reg + 32'h1;
               if (step_cnt_reg == '0) begin
                  case (cmd_reg.op)
                     `OP_READ_IN: IN_SNAP <= DIG_IN;
                     `OP_SET_OUT: DIG_OUT <= cmd_reg.arg[IO_BITS-1:0];
                     `OP_SET_ACCEL: ACCEL <= cmd_reg.arg;
                     `OP_MOVE, `OP_MOVE_WAIT: begin
                        MOTION.start <= 1'b1;
                        MOTION.target <= cmd_reg.arg;
                     end
                     default: ;
                  endcase
               end
               if (step_cnt_reg == 32'(STEP_CYC - 1)) begin
                  step_cnt_reg <= '0;
                  if (cmd_reg.op == `OP_HOME) begin
                     home_from_auto_reg <= auto_run_reg;
                     cam_seen_reg <= 1'b0;
                     state_reg <= pos_seq_pkg::ST_HOME_CAM;
                  end else if (cmd_reg.op == `OP_MOVE_WAIT) begin
                     state_reg <= pos_seq_pkg::ST_WAIT_POS;
                  end else if (cmd_reg.op == `OP_END || !auto_run_reg) begin
                     PROG_DONE <= auto_run_reg;
                     state_reg <= pos_seq_pkg::ST_IDLE;
                  end else begin
                     state_reg <= pos_seq_pkg::ST_FETCH;
                  end
               end
            end
            pos_seq_pkg::ST_WAIT_POS: begin
               if (TARGET_REACHED) begin
                  step_cnt_reg <= '0;
                  state_reg <= pos_seq_pkg::ST_WAIT_EXTRA;
               end
            end
            pos_seq_pkg::ST_WAIT_EXTRA: begin
               step_cnt_reg <= step_cnt_reg + 32'h1;
               if (step_cnt_reg == 32'(EXTRA_CYC - 1)) begin
                  step_cnt_reg <= '0;
                  state_reg <= auto_run_reg ? pos_seq_pkg::ST_FETCH
                                            : pos_seq_pkg::ST_IDLE;
               end
            end
            pos_seq_pkg::ST_HOME_CAM: begin
               MOTION.jog_run <= 1'b1;
               MOTION.jog_dir_neg <= 1'b0;
               MOTION.jog_fast <= 1'b0;
               if (REFERENCE_CAM_INPUT) begin
                  cam_seen_reg <= 1'b1;
                  state_reg <= pos_seq_pkg::ST_HOME_ZERO;
               end
            end
            pos_seq_pkg::ST_HOME_ZERO: begin
               MOTION.jog_run <= 1'b1;
               MOTION.jog_dir_neg <= 1'b0;
               MOTION.jog_fast <= 1'b0;
               if (cam_seen_reg && ENC_POS == '0) begin
                  MOTION.jog_run <= 1'b0;
                  state_reg <= home_from_auto_reg ? pos_seq_pkg::ST_FETCH
                                                  : pos_seq_pkg::ST_IDLE;
               end
            end
            default: state_reg <= pos_seq_pkg::ST_IDLE;
         endcase
      end
   end

endmodule

// ==== dv/pos_seq_properties.sv ====
`timescale 1ns/1ps
module pos_seq_properties #(
   parameter int STEP_CYC = 200000,
   parameter int LOOP_CYC = 50000
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic PROGRAM_RUN_SELECT_INPUT,
   input wire logic HOST_CMD_VALID,
   input wire pos_seq_pkg::cmd_t HOST_CMD,
   input wire logic JOG_FWD_INPUT,
   input wire logic JOG_REV_INPUT,
   input wire logic HOST_JOG_REV,
   input wire logic HOME_REQ,
   input wire logic ENDLESS_AXIS,
   input wire logic [15:0] ENC_POS,
   input wire logic [7:0] DIG_OUT,
   input wire pos_seq_pkg::motion_t MOTION,
   input wire pos_seq_pkg::op_mode_t MODE,
   input wire logic HOST_CMD_BUSY,
   input wire logic REF_VALID,
   input wire logic LOOP_TICK
);
   int lcnt_reg, gcnt_reg, bcnt_reg;
   logic lseen_reg, gseen_reg, man, fwd_only;
   assign man = MODE == pos_seq_pkg::MODE_MANUAL;
   assign fwd_only = man && !HOST_CMD_BUSY && !HOME_REQ && JOG_FWD_INPUT
      && !JOG_REV_INPUT && !HOST_JOG_REV && !PROGRAM_RUN_SELECT_INPUT;
   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         lcnt_reg <= 0;
         lseen_reg <= 1'b0;
      end else begin
         lcnt_reg <= LOOP_TICK ? 0 : lcnt_reg + 1;
         lseen_reg <= lseen_reg | LOOP_TICK;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         gcnt_reg <= 0;
         gseen_reg <= 1'b0;
      end else begin
         gcnt_reg <= MOTION.start ? 0 : gcnt_reg + 1;
         gseen_reg <= gseen_reg | MOTION.start;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         bcnt_reg <= 0;
      end else begin
         bcnt_reg <= HOST_CMD_BUSY ? bcnt_reg + 1 : 0;
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   loop_period_a: assert property (
      LOOP_TICK && lseen_reg |-> lcnt_reg == LOOP_CYC - 1)
      else $error("loop tick period wrong");
   step_gap_a: assert property (
      MOTION.start && !man && gseen_reg |-> gcnt_reg >= STEP_CYC)
      else $error("program step too short");
   busy_len_a: assert property (
      $fell(HOST_CMD_BUSY) |-> bcnt_reg >= STEP_CYC)
      else $error("host command step too short");
   busy_manual_a: assert property (
      $rose(HOST_CMD_BUSY) |-> $past(MODE) == pos_seq_pkg::MODE_MANUAL)
      else $error("host command outside manual");
   host_out_a: assert property (
      HOST_CMD_VALID && HOST_CMD.op == 3'h2 && man && !HOST_CMD_BUSY
      && !HOME_REQ && !PROGRAM_RUN_SELECT_INPUT
      |-> ##2 DIG_OUT == $past(HOST_CMD.arg[7:0], 2))
      else $error("outputs not set by host command");
   manual_start_a: assert property (
      MOTION.start && man |-> $past(HOST_CMD_VALID, 2))
      else $error("manual move without host command");
   jog_fwd_a: assert property (
      fwd_only [*3] |-> MOTION.jog_run && !MOTION.jog_dir_neg)
      else $error("forward jog missing");
   ref_origin_a: assert property (
      $rose(REF_VALID) |-> $past(ENDLESS_AXIS)
      || $past(MODE) == pos_seq_pkg::MODE_HOMING)
      else $error("reference valid without homing");
   ref_zero_a: assert property (
      $rose(REF_VALID) && !$past(ENDLESS_AXIS)
      |-> $past(ENC_POS) == 16'h0 || $past(ENC_POS, 2) == 16'h0)
      else $error("reference set away from zero");
endmodule

// ==== dv/pos_far_side.sv ====
`timescale 1ns/1ps
module pos_far_side #(
   parameter int REACH_CYC = 30
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire pos_seq_pkg::motion_t motion,
   output logic [15:0] enc_pos,
   output logic cam,
   output logic reached
);
   int wait_reg;
   // ---------------------------------------------------------------
   // encoder and cam, one turn in 16 cycles
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         enc_pos <= 16'h4000;
      end else if (motion.jog_run) begin
         enc_pos <= enc_pos + (motion.jog_dir_neg ? 16'hf000 : 16'h1000);
      end
   end
   assign cam = enc_pos[15:12] == 4'h8;
   // settling time after each move start
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wait_reg <= 0;
      end else if (motion.start) begin
         wait_reg <= REACH_CYC;
      end else if (wait_reg != 0) begin
         wait_reg <= wait_reg - 1;
      end
   end
   assign reached = wait_reg == 0;
endmodule

// ==== dv/test_positioning_mode_sequencer.sv ====
`timescale 1ns/1ps
`include "pos_seq_map.svh"
module test_positioning_mode_sequencer;
   localparam int STEP = 20;
   localparam int EXTRA = 20;
   localparam logic [2:0] OPS [8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h1,
      3'h0, 3'h6, 3'h7};
   logic clk, rst_b, run, start, pwr, hv, hjf, hjr, jf, jr, jfast, home;
   logic endless, busy, refv, tick, done, cam, reached;
   logic [3:0] psel;
   logic [7:0] paddr, din, dout, snap;
   logic [15:0] accel, enc, r;
   pos_seq_pkg::cmd_t pdata, hc;
   pos_seq_pkg::motion_t mot;
   pos_seq_pkg::op_mode_t mode;
   int seed = 16742;
   int bad_count, comparisons, n;
   time t0;
   positioning_mode_sequencer #(.STEP_CYC(STEP), .EXTRA_CYC(EXTRA),
      .LOOP_CYC(10)) u_positioning_mode_sequencer (
      .CORE_CLK(clk), .RST_B(rst_b), .PROGRAM_RUN_SELECT_INPUT(run),
      .START(start), .PROG_SEL(psel), .PROG_WR(pwr),
      .PROG_WR_ADDR(paddr), .PROG_WR_DATA(pdata), .HOST_CMD_VALID(hv),
      .HOST_CMD(hc), .HOST_JOG_FWD(hjf), .HOST_JOG_REV(hjr),
      .JOG_FWD_INPUT(jf), .JOG_REV_INPUT(jr), .JOG_FAST(jfast),
      .HOME_REQ(home), .REFERENCE_CAM_INPUT(cam), .ENDLESS_AXIS(endless),
      .ENC_POS(enc), .TARGET_REACHED(reached), .DIG_IN(din),
      .DIG_OUT(dout), .ACCEL(accel), .IN_SNAP(snap), .MOTION(mot),
      .MODE(mode), .HOST_CMD_BUSY(busy), .REF_VALID(refv),
      .LOOP_TICK(tick), .PROG_DONE(done));
   pos_far_side u_pos_far_side (.clk(clk), .rst_b(rst_b), .motion(mot),
      .enc_pos(enc), .cam(cam), .reached(reached));
   task check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task wait_on(input int sel);
      for (n = 0; n < 2000; n++) begin
         @(posedge clk);
         #1;
         if ((sel == 0 && busy === 1'b0) || (sel == 1 && refv === 1'b1)
            || (sel == 2 && done === 1'b1)) break;
      end
      if (n == 2000) begin
         bad_count++;
         final_report;
      end
   endtask
   task host(input logic [2:0] op, input logic [15:0] arg);
      @(negedge clk);
      hv = 1'b1;
      hc = '{op, arg};
      @(negedge clk);
      hv = 1'b0;
      wait_on(0);
   endtask
   function int min_run;
      min_run = 0;
      for (int k = 0; k < 8; k++) begin
         if (OPS[k] < 3'h6) min_run += STEP + 1;
      end
      min_run += EXTRA;
   endfunction
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {rst_b, run, start, pwr, hv, hjf, hjr, jf, jr, jfast, home} = '0;
      endless = 1'b0;
      psel = 4'h2;
      {paddr, din, pdata, hc} = '0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      check(mode, pos_seq_pkg::MODE_MANUAL);
      check(refv, 1'b0);
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         din = r[15:8];
         host(`OP_SET_OUT, r);
         check(dout, r[7:0]);
         host(`OP_SET_ACCEL, r);
         check(accel, r);
         host(`OP_READ_IN, r);
         check(snap, din);
         host(`OP_MOVE, r);
         check(mot.target, r);
      end
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         {hjr, hjf, jr, jf} = (i == 4) ? 4'h3 : 4'h1 << i;
         jfast = i[0];
         repeat (4) @(negedge clk);
         check(mot.jog_run, i < 4);
         if (i < 4) check(mot.jog_dir_neg, i[0]);
         if (i < 4) check(mot.jog_fast, i[0]);
      end
      {hjr, hjf, jr, jf} = 4'h0;
      repeat (4) @(negedge clk);
      home = 1'b1;
      @(negedge clk);
      home = 1'b0;
      @(negedge clk);
      check(mode, pos_seq_pkg::MODE_HOMING);
      wait_on(1);
      repeat (3) @(negedge clk);
      check(mode, pos_seq_pkg::MODE_MANUAL);
      check(mot.jog_run, 1'b0);
      r = $random(seed);
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         pwr = 1'b1;
         paddr = {psel, i[3:0]};
         pdata = '{OPS[i], r};
      end
      @(negedge clk);
      pwr = 1'b0;
      din = r[11:4];
      run = 1'b1;
      repeat (20 * STEP) @(negedge clk);
      check(mode, pos_seq_pkg::MODE_AUTO);
      start = 1'b1;
      t0 = $time;
      @(negedge clk);
      start = 1'b0;
      wait_on(2);
      check(($time - t0) / 5 >= min_run(), 1'b1);
      check(dout, r[7:0]);
      check(accel, r);
      check(snap, din);
      check(mot.target, r);
      check(refv, 1'b1);
      @(negedge clk);
      run = 1'b0;
      repeat (STEP + 4) @(negedge clk);
      check(mode, pos_seq_pkg::MODE_MANUAL);
      endless = 1'b1;
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
      check(refv, 1'b1);
      final_report;
   end
endmodule
bind positioning_mode_sequencer pos_seq_properties #(
   .STEP_CYC(STEP_CYC), .LOOP_CYC(LOOP_CYC)) u_pos_seq_properties (
   .CORE_CLK(CORE_CLK), .RST_B(RST_B), .HOST_CMD(HOST_CMD),
   .PROGRAM_RUN_SELECT_INPUT(PROGRAM_RUN_SELECT_INPUT),
   .HOST_CMD_VALID(HOST_CMD_VALID), .JOG_FWD_INPUT(JOG_FWD_INPUT),
   .JOG_REV_INPUT(JOG_REV_INPUT), .HOST_JOG_REV(HOST_JOG_REV),
   .HOME_REQ(HOME_REQ), .ENDLESS_AXIS(ENDLESS_AXIS), .ENC_POS(ENC_POS),
   .DIG_OUT(DIG_OUT), .MOTION(MOTION), .MODE(MODE),
   .HOST_CMD_BUSY(HOST_CMD_BUSY), .REF_VALID(REF_VALID),
   .LOOP_TICK(LOOP_TICK));
